// ### rtl/mbs_crc16.sv
`timescale 1ns/1ps
module mbs_crc16 (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Byte stream
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] din,
	// Running remainder
	output logic [15:0] crc
);
	import mbs_pkg::*;

	logic [15:0] crc_reg;
	logic [15:0] crc_next;

	always_comb begin
		crc_next = crc_reg ^ {8'h00, din};
		for (int i = 0; i < 8; i++) begin
			crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY) :
				(crc_next >> 1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_reg <= CRC_INIT;
		end else if (clr) begin
			crc_reg <= CRC_INIT;
		end else if (en) begin
			crc_reg <= crc_next;
		end
	end

	assign crc = crc_reg;
endmodule

// ### rtl/mbs_pkg.sv
package mbs_pkg;

	// ********************************************
	// Register numbers (printed numbering)
	// ********************************************
	localparam logic [15:0] REG_BASE = 16'h9c41;
	localparam logic [15:0] REG_TEMP = 16'h9c67;
	localparam logic [15:0] REG_SLAVE = 16'h9d3b;
	localparam logic [15:0] REG_BAUD = 16'h9d3c;
	localparam logic [15:0] REG_PARITY = 16'h9d3d;
	localparam logic [15:0] REG_STOP = 16'h9d3e;
	localparam logic [15:0] REG_NVW0 = 16'h9e2b;
	localparam logic [15:0] REG_NVW1 = 16'h9e2c;
	localparam logic [15:0] REG_BULK_VAL = 16'ha474;
	localparam logic [15:0] REG_BULK_PTR = 16'ha4d8;
	localparam logic [15:0] BULK_N = 16'h0064;
	localparam logic [15:0] SRC_MIN = 16'h9c55;
	localparam logic [15:0] SRC_MAX = 16'ha473;

	// ********************************************
	// Reset values and legal ranges
	// ********************************************
	localparam logic [15:0] SLAVE_RST = 16'h0001;
	localparam logic [15:0] BAUD_RST = 16'h0009;
	localparam logic [15:0] PARITY_RST = 16'h0000;
	localparam logic [15:0] STOP_RST = 16'h0000;
	localparam logic [15:0] SLAVE_MAX = 16'h0040;
	localparam logic [15:0] BAUD_CODE_HI = 16'h0009;
	localparam logic [15:0] BAUD_CODE_LO = 16'h000a;
	localparam logic [15:0] PARITY_MAX = 16'h0004;
	localparam logic [15:0] STOP_MAX = 16'h0001;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_ODD = 3'h1;
	localparam logic [2:0] PAR_EVEN = 3'h2;
	localparam logic [2:0] PAR_MARK = 3'h3;
	localparam logic [1:0] NV_LAST = 2'h3;

	// ********************************************
	// Protocol codes
	// ********************************************
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h06;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VAL = 8'h03;
	localparam logic [7:0] EXC_DENY = 8'h04;
	localparam logic [15:0] RD_MAX = 16'h007d;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	// ********************************************
	// Timing
	// ********************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_HI_BPS = 38400;
	localparam int unsigned BAUD_LO_BPS = 19200;
	localparam logic [15:0] DIV_HI = 16'(CLK_HZ / BAUD_HI_BPS);
	localparam logic [15:0] DIV_LO = 16'(CLK_HZ / BAUD_LO_BPS);
	localparam int unsigned T35_BITS = 39;
	localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
	localparam int unsigned READY_TIME_S = 70;
	localparam int unsigned READY_MS_DEF = READY_TIME_S * 1000;
	localparam int unsigned SAVE_TIME_MIN = 60;
	localparam int unsigned SAVE_MS_DEF = SAVE_TIME_MIN * 60000;
	localparam int unsigned NV_CNT_W = 60;

endpackage

// ### rtl/mbs_slave.sv
// Function
// - Slave address 0..64, default 1, live
// - Baud code 9 is 38400, 10 19200
// - Parity codes 0..4, 0 means none
// - Stop code 0 one bit, 1 two
// - Unready for up to 70 s
// - Temperature reads zero until ready
// - Only functions 03 and 06 supported
// - Read returns each register high byte first
// - Write single updates addressed register
// - Up to 100 sources in 40021..42099
// - Pointer table selects value window contents
// - Pointer table volatile, cleared by power cycle
// - Power-up copies nonvolatile values into registers
// - Bus writes change volatile copy only
// - Nonvolatile writes counted, 60-bit counter
// - Statistics saved hourly and on power loss
// - Line settings apply after power cycle
`timescale 1ns/1ps
module mbs_slave #(
	parameter int unsigned MS_DIV = mbs_pkg::MS_CYCLES,
	parameter int unsigned READY_MS = mbs_pkg::READY_MS_DEF,
	parameter int unsigned SAVE_MS = mbs_pkg::SAVE_MS_DEF,
	parameter int unsigned BIT_DIV_HI = mbs_pkg::DIV_HI,
	parameter int unsigned BIT_DIV_LO = mbs_pkg::DIV_LO
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial line
	input wire logic rxd,
	output logic txd,
	output logic tx_oe,
	// Nonvolatile store
	output logic [1:0] nv_rd_idx,
	input wire logic [15:0] nv_rd_data,
	output logic nv_save,
	input wire logic mains_lost,
	// Application registers
	output logic [15:0] app_addr,
	input wire logic [15:0] app_rdata,
	output logic app_wr,
	output logic [15:0] app_wdata,
	// Status
	input wire logic wr_permit,
	input wire logic [15:0] temp_raw,
	output logic ready
);
	import mbs_pkg::*;

	typedef enum logic [3:0] {S_LOAD, S_RX, S_EXEC, S_HDR, S_FETCH,
		S_GET, S_DHI, S_DLO, S_CRL, S_CRH} mbs_state_e;

	function automatic logic in_win(input logic [15:0] x,
		input logic [15:0] b);
		return (x >= b) && (x < b + BULK_N);
	endfunction

	mbs_state_e state_reg;
	logic [15:0] slave_reg, baud_reg, par_reg, stop_reg;
	logic [15:0] lnk_div_reg;
	logic [2:0] lnk_par_reg;
	logic lnk_stop_reg;
	logic [1:0] nv_idx_reg;
	logic [31:0] ms_cnt_reg, up_ms_reg, save_ms_reg;
	logic ready_reg, mains_reg, nv_save_reg;
	logic [NV_CNT_W-1:0] nv_cnt_reg;
	logic [7:0] rb [6];
	logic [3:0] len_reg;
	logic bad_reg;
	logic [7:0] hdr [6];
	logic [2:0] hidx_reg, hn_reg;
	logic [15:0] raddr_reg, cur_reg, data_reg, left_reg;
	logic null_reg, app_wr_reg;
	logic [15:0] app_wdata_reg;
	logic [15:0] ptr_mem [100];

	logic rx_valid, rx_err, rx_gap, tx_ready;
	logic [7:0] rx_data, tx_byte;
	logic [15:0] rx_crc, tx_crc, rd_val;

	// ********************************************
	// Request decode
	// ********************************************
	wire [7:0] fn = rb[1];
	wire [15:0] pa = {rb[2], rb[3]} + REG_BASE;
	wire [15:0] pv = {rb[4], rb[5]};
	wire is_rd = fn == FC_READ;
	wire is_wr = fn == FC_WRITE;
	wire len_ok = len_reg == 4'h8;
	wire addr_hit = {8'h00, rb[0]} == slave_reg;
	wire frame_ok = rx_gap && len_reg >= 4'h4 && !bad_reg &&
		rx_crc == 16'h0000 && addr_hit;
	wire bad_val = (pa == REG_SLAVE && pv > SLAVE_MAX) ||
		(pa == REG_BAUD && pv != BAUD_CODE_HI && pv != BAUD_CODE_LO) ||
		(pa == REG_PARITY && pv > PARITY_MAX) ||
		(pa == REG_STOP && pv > STOP_MAX);
	wire ro_hit = pa == REG_TEMP || pa == REG_NVW0 || pa == REG_NVW1 ||
		in_win(pa, REG_BULK_VAL);
	wire [7:0] wr_exc = !wr_permit ? EXC_DENY : ro_hit ? EXC_ADDR :
		bad_val ? EXC_VAL : 8'h00;
	wire [7:0] rd_exc = (pv == 16'h0000 || pv > RD_MAX) ? EXC_VAL : 8'h00;
	wire [7:0] exc = is_rd ? rd_exc : is_wr ? wr_exc : EXC_FUNC;
	wire in_exec = state_reg == S_EXEC;
	wire drop = (is_rd || is_wr) && !len_ok;
	wire do_wr = in_exec && is_wr && len_ok && wr_exc == 8'h00;
	wire own_wr = pa == REG_SLAVE || pa == REG_BAUD || pa == REG_PARITY ||
		pa == REG_STOP || in_win(pa, REG_BULK_PTR);
	wire [15:0] vidx = raddr_reg - REG_BULK_VAL;
	wire [15:0] pidx = cur_reg - REG_BULK_PTR;
	wire [15:0] widx = pa - REG_BULK_PTR;
	wire [15:0] src = ptr_mem[vidx[6:0]];
	wire src_ok = src >= SRC_MIN && src <= SRC_MAX;

	wire tx_valid = state_reg == S_HDR || state_reg == S_DHI ||
		state_reg == S_DLO || state_reg == S_CRL || state_reg == S_CRH;
	wire tx_go = tx_valid && tx_ready;
	wire tx_crc_en = tx_go && state_reg != S_CRL && state_reg != S_CRH;
	wire rx_en = ready_reg && state_reg == S_RX && tx_ready;
	wire rx_clr = state_reg != S_RX || (rx_gap && !frame_ok);
	wire ms_tick = ms_cnt_reg == 32'(MS_DIV - 1);
	wire save_due = ms_tick && save_ms_reg == 32'(SAVE_MS - 1);
	wire load_end = state_reg == S_LOAD && nv_idx_reg == NV_LAST;

	always_comb begin
		case (state_reg)
			S_HDR: tx_byte = hdr[hidx_reg];
			S_DHI: tx_byte = data_reg[15:8];
			S_DLO: tx_byte = data_reg[7:0];
			S_CRL: tx_byte = tx_crc[7:0];
			S_CRH: tx_byte = tx_crc[15:8];
			default: tx_byte = 8'h00;
		endcase
	end

	// ********************************************
	// Register read selection
	// ********************************************
	always_comb begin
		rd_val = app_rdata;
		if (null_reg) begin
			rd_val = 16'h0000;
		end else if (cur_reg == REG_TEMP) begin
			rd_val = ready_reg ? temp_raw : 16'h0000;
		end else if (cur_reg == REG_SLAVE) begin
			rd_val = slave_reg;
		end else if (cur_reg == REG_BAUD) begin
			rd_val = baud_reg;
		end else if (cur_reg == REG_PARITY) begin
			rd_val = par_reg;
		end else if (cur_reg == REG_STOP) begin
			rd_val = stop_reg;
		end else if (cur_reg == REG_NVW0) begin
			rd_val = nv_cnt_reg[15:0];
		end else if (cur_reg == REG_NVW1) begin
			rd_val = nv_cnt_reg[31:16];
		end else if (in_win(cur_reg, REG_BULK_PTR)) begin
			rd_val = ptr_mem[pidx[6:0]];
		end
	end

	// ********************************************
	// Power-up, readiness and nonvolatile saves
	// ********************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_reg <= 32'h0000_0000;
			up_ms_reg <= 32'h0000_0000;
			save_ms_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
		end else begin
			ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h1;
			if (ms_tick && up_ms_reg != 32'(READY_MS)) begin
				up_ms_reg <= up_ms_reg + 32'h1;
			end
			if (ms_tick) begin
				save_ms_reg <= save_due ? 32'h0 : save_ms_reg + 32'h1;
			end
			ready_reg <= up_ms_reg == 32'(READY_MS) && state_reg != S_LOAD;
		end
	end

	// Only statistics saves reach the store; bus writes never do
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mains_reg <= 1'b0;
			nv_save_reg <= 1'b0;
			nv_cnt_reg <= '0;
		end else begin
			mains_reg <= mains_lost;
			nv_save_reg <= save_due || (mains_lost && !mains_reg);
			nv_cnt_reg <= nv_cnt_reg + NV_CNT_W'(nv_save_reg);
		end
	end

	// ********************************************
	// Configuration registers
	// ********************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_reg <= SLAVE_RST;
			baud_reg <= BAUD_RST;
			par_reg <= PARITY_RST;
			stop_reg <= STOP_RST;
			nv_idx_reg <= 2'h0;
		end else if (state_reg == S_LOAD) begin
			nv_idx_reg <= nv_idx_reg + 2'h1;
			case (nv_idx_reg)
				2'h0: slave_reg <= nv_rd_data;
				2'h1: baud_reg <= nv_rd_data;
				2'h2: par_reg <= nv_rd_data;
				default: stop_reg <= nv_rd_data;
			endcase
		end else if (do_wr) begin
			case (pa)
				REG_SLAVE: slave_reg <= pv;
				REG_BAUD: baud_reg <= pv;
				REG_PARITY: par_reg <= pv;
				REG_STOP: stop_reg <= pv;
				default: ;
			endcase
		end
	end

	// Line format is frozen when loading ends, so a write waits a power cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lnk_div_reg <= 16'(BIT_DIV_HI);
			lnk_par_reg <= PAR_NONE;
			lnk_stop_reg <= 1'b0;
		end else if (load_end) begin
			lnk_div_reg <= baud_reg == BAUD_CODE_LO ? 16'(BIT_DIV_LO) :
				16'(BIT_DIV_HI);
			lnk_par_reg <= par_reg[2:0];
			lnk_stop_reg <= nv_rd_data[0];
		end
	end

	// Pointer table lives in plain storage; any reset empties it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 100; i++) begin
				ptr_mem[i] <= 16'h0000;
			end
		end else if (do_wr && in_win(pa, REG_BULK_PTR)) begin
			ptr_mem[widx[6:0]] <= pv;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			app_wr_reg <= 1'b0;
			app_wdata_reg <= 16'h0000;
		end else begin
			app_wr_reg <= do_wr && !own_wr;
			if (do_wr) begin
				app_wdata_reg <= pv;
			end
		end
	end

	// ********************************************
	// Frame collection
	// ********************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			len_reg <= 4'h0;
			bad_reg <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				rb[i] <= 8'h00;
			end
		end else if (rx_clr) begin
			len_reg <= 4'h0;
			bad_reg <= 1'b0;
		end else if (rx_valid) begin
			if (len_reg < 4'h6) begin
				rb[len_reg[2:0]] <= rx_data;
			end
			if (len_reg == 4'h8) begin
				bad_reg <= 1'b1;
			end else begin
				len_reg <= len_reg + 4'h1;
			end
			if (rx_err) begin
				bad_reg <= 1'b1;
			end
		end
	end

	// ********************************************
	// Command sequencer
	// ********************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_LOAD;
			hidx_reg <= 3'h0;
			hn_reg <= 3'h0;
			raddr_reg <= 16'h0000;
			cur_reg <= 16'h0000;
			data_reg <= 16'h0000;
			left_reg <= 16'h0000;
			null_reg <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				hdr[i] <= 8'h00;
			end
		end else begin
			case (state_reg)
				S_LOAD: begin
					if (nv_idx_reg == NV_LAST) begin
						state_reg <= S_RX;
					end
				end
				S_RX: begin
					if (frame_ok) begin
						state_reg <= S_EXEC;
					end
				end
				S_EXEC: begin
					hidx_reg <= 3'h0;
					raddr_reg <= pa;
					cur_reg <= pa;
					null_reg <= 1'b0;
					left_reg <= pv;
					hdr[0] <= rb[0];
					if (drop) begin
						state_reg <= S_RX;
					end else if (exc != 8'h00) begin
						state_reg <= S_HDR;
						hdr[1] <= fn | EXC_FLAG;
						hdr[2] <= exc;
						hn_reg <= 3'h3;
						left_reg <= 16'h0000;
					end else if (is_rd) begin
						state_reg <= S_HDR;
						hdr[1] <= fn;
						hdr[2] <= {pv[6:0], 1'b0};
						hn_reg <= 3'h3;
					end else begin
						state_reg <= S_HDR;
						for (int i = 1; i < 6; i++) begin
							hdr[i] <= rb[i];
						end
						hn_reg <= 3'h6;
						left_reg <= 16'h0000;
					end
				end
				S_HDR: begin
					if (tx_go) begin
						hidx_reg <= hidx_reg + 3'h1;
						if (hidx_reg == hn_reg - 3'h1) begin
							state_reg <= left_reg != 16'h0000 ? S_FETCH : S_CRL;
						end
					end
				end
				S_FETCH: begin
					state_reg <= S_GET;
					if (in_win(raddr_reg, REG_BULK_VAL)) begin
						cur_reg <= src;
						null_reg <= !src_ok;
					end else begin
						cur_reg <= raddr_reg;
						null_reg <= 1'b0;
					end
				end
				S_GET: begin
					data_reg <= rd_val;
					state_reg <= S_DHI;
				end
				S_DHI: begin
					if (tx_go) begin
						state_reg <= S_DLO;
					end
				end
				S_DLO: begin
					if (tx_go) begin
						raddr_reg <= raddr_reg + 16'h0001;
						left_reg <= left_reg - 16'h0001;
						state_reg <= left_reg == 16'h0001 ? S_CRL : S_FETCH;
					end
				end
				S_CRL: begin
					if (tx_go) begin
						state_reg <= S_CRH;
					end
				end
				S_CRH: begin
					if (tx_go) begin
						state_reg <= S_RX;
					end
				end
				default: state_reg <= S_RX;
			endcase
		end
	end

	// ********************************************
	// Line and checksums
	// ********************************************
	mbs_uart u_uart (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.bit_div(lnk_div_reg),
		.parity_mode(lnk_par_reg),
		.two_stop(lnk_stop_reg),
		.rx_en(rx_en),
		.rxd(rxd),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_err(rx_err),
		.rx_gap(rx_gap),
		.tx_valid(tx_valid),
		.tx_data(tx_byte),
		.tx_ready(tx_ready),
		.txd(txd),
		.tx_oe(tx_oe)
	);

	mbs_crc16 u_rx_crc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(rx_clr),
		.en(rx_valid),
		.din(rx_data),
		.crc(rx_crc)
	);

	mbs_crc16 u_tx_crc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(in_exec),
		.en(tx_crc_en),
		.din(tx_byte),
		.crc(tx_crc)
	);

	assign nv_rd_idx = nv_idx_reg;
	assign nv_save = nv_save_reg;
	assign app_addr = cur_reg;
	assign app_wr = app_wr_reg;
	assign app_wdata = app_wdata_reg;
	assign ready = ready_reg;
endmodule

// ### rtl/mbs_uart.sv
`timescale 1ns/1ps
module mbs_uart #(
	parameter int unsigned GAP_BITS = mbs_pkg::T35_BITS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Line format
	input wire logic [15:0] bit_div,
	input wire logic [2:0] parity_mode,
	input wire logic two_stop,
	// Receive side
	input wire logic rx_en,
	input wire logic rxd,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	output logic rx_gap,
	// Transmit side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic txd,
	output logic tx_oe
);
	import mbs_pkg::*;

	function automatic logic par_of(input logic [7:0] d,
		input logic [2:0] m);
		case (m)
			PAR_ODD: return ~^d;
			PAR_EVEN: return ^d;
			PAR_MARK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	wire par_en = parity_mode != PAR_NONE;
	wire [3:0] rx_last = par_en ? 4'ha : 4'h9;

	// ********************************************
	// Receiver, sampling at mid bit
	// ********************************************
	logic rx_busy_reg, rx_perr_reg, rx_valid_reg, rx_err_reg;
	logic [15:0] rx_cnt_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_sh_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_err_reg <= 1'b0;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 4'h0;
			rx_sh_reg <= 8'h00;
		end else begin
			rx_valid_reg <= 1'b0;
			if (!rx_busy_reg) begin
				if (rx_en && !rxd) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg <= bit_div >> 1;
					rx_bit_reg <= 4'h0;
					rx_perr_reg <= 1'b0;
				end
			end else if (rx_cnt_reg != 16'h0000) begin
				rx_cnt_reg <= rx_cnt_reg - 16'h0001;
			end else begin
				rx_cnt_reg <= bit_div - 16'h0001;
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0) begin
					rx_busy_reg <= ~rxd;
				end else if (rx_bit_reg <= 4'h8) begin
					rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
				end else if (rx_bit_reg == rx_last) begin
					rx_busy_reg <= 1'b0;
					rx_valid_reg <= 1'b1;
					rx_err_reg <= rx_perr_reg | ~rxd;
				end else begin
					rx_perr_reg <= rxd != par_of(rx_sh_reg, parity_mode);
				end
			end
		end
	end

	// ********************************************
	// Silence detector, marks end of frame
	// ********************************************
	logic [15:0] gap_cnt_reg;
	logic [5:0] gap_bits_reg;
	logic gap_done_reg, gap_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt_reg <= 16'h0000;
			gap_bits_reg <= 6'h00;
			gap_done_reg <= 1'b0;
			gap_reg <= 1'b0;
		end else begin
			gap_reg <= 1'b0;
			if (rx_busy_reg || !rxd) begin
				gap_cnt_reg <= 16'h0000;
				gap_bits_reg <= 6'h00;
				gap_done_reg <= 1'b0;
			end else if (!gap_done_reg) begin
				if (gap_cnt_reg == bit_div - 16'h0001) begin
					gap_cnt_reg <= 16'h0000;
					gap_bits_reg <= gap_bits_reg + 6'h01;
					if (gap_bits_reg == 6'(GAP_BITS - 1)) begin
						gap_done_reg <= 1'b1;
						gap_reg <= 1'b1;
					end
				end else begin
					gap_cnt_reg <= gap_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// ********************************************
	// Transmitter
	// ********************************************
	logic tx_busy_reg, txd_reg;
	logic [15:0] tx_cnt_reg;
	logic [11:0] tx_sh_reg;
	logic [3:0] tx_n_reg;

	// Stop bits are the ones above the frame; a second one only lengthens
	wire [11:0] tx_frame = par_en ?
		{2'b11, par_of(tx_data, parity_mode), tx_data, 1'b0} :
		{3'b111, tx_data, 1'b0};
	wire [3:0] tx_len = 4'h9 + {3'h0, par_en} + {3'h0, two_stop};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_reg <= 1'b0;
			txd_reg <= 1'b1;
			tx_cnt_reg <= 16'h0000;
			tx_sh_reg <= 12'hfff;
			tx_n_reg <= 4'h0;
		end else if (!tx_busy_reg) begin
			if (tx_valid) begin
				tx_busy_reg <= 1'b1;
				txd_reg <= 1'b0;
				tx_sh_reg <= tx_frame >> 1;
				tx_n_reg <= tx_len;
				tx_cnt_reg <= bit_div - 16'h0001;
			end
		end else if (tx_cnt_reg != 16'h0000) begin
			tx_cnt_reg <= tx_cnt_reg - 16'h0001;
		end else if (tx_n_reg == 4'h0) begin
			tx_busy_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			txd_reg <= tx_sh_reg[0];
			tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
			tx_n_reg <= tx_n_reg - 4'h1;
			tx_cnt_reg <= bit_div - 16'h0001;
		end
	end

	assign rx_valid = rx_valid_reg;
	assign rx_data = rx_sh_reg;
	assign rx_err = rx_err_reg;
	assign rx_gap = gap_reg;
	assign tx_ready = ~tx_busy_reg;
	assign txd = txd_reg;
	assign tx_oe = tx_busy_reg;
endmodule

// ### tb/mbs_master_model.sv
`timescale 1ns/1ps
module mbs_master_model
	import mbs_pkg::*;
#(
	parameter int unsigned BIT_DIV = DIV_HI
) (
	// Clock
	input wire logic sys_clk,
	// Serial line
	output logic rxd,
	input wire logic txd
);
	logic [7:0] rsp_q[$];
	initial rxd = 1'b1;
	function automatic logic [15:0] crc_upd(input logic [15:0] c,
		input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	task automatic bits(input int n);
		repeat (n * BIT_DIV) @(posedge sys_clk);
	endtask
	task automatic put(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		// No parity bit, one full stop bit
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			bits(1);
		end
	endtask
	task automatic send(input logic [47:0] q);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 5; i >= 0; i--) begin
			put(q[i * 8 +: 8]);
			c = crc_upd(c, q[i * 8 +: 8]);
		end
		put(c[7:0]);
		put(c[15:8]);
	endtask
	// Collects characters until 50 bit times pass with no start bit
	task automatic recv();
		int t;
		logic [7:0] b;
		rsp_q = {};
		t = 0;
		while (t < 50 * BIT_DIV) begin
			@(posedge sys_clk);
			t++;
			if (txd === 1'b0) begin
				repeat (BIT_DIV + BIT_DIV / 2) @(posedge sys_clk);
				for (int i = 0; i < 8; i++) begin
					b[i] = txd;
					bits(1);
				end
				rsp_q.push_back(b);
				t = 0;
			end
		end
	endtask
endmodule

// ### tb/mbs_slave_checker.sv
`timescale 1ns/1ps
module mbs_slave_checker
	import mbs_pkg::*;
#(
	parameter int unsigned MS_DIV = 10,
	parameter int unsigned SAVE_MS = 5,
	parameter int unsigned BIT_DIV = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic txd,
	input wire logic tx_oe,
	input wire logic [1:0] nv_rd_idx,
	input wire logic nv_save,
	input wire logic mains_lost,
	input wire logic app_wr,
	input wire logic ready
);
	localparam int unsigned SAVE_CYC = SAVE_MS * MS_DIV;
	int unsigned gap_reg;
	int unsigned gap_next;
	logic [15:0] hi_reg;
	logic [15:0] hi_next;
	// Saturate so a long idle never wraps into a short count
	assign hi_next = !txd ? 16'h0000 : (&hi_reg ? hi_reg : hi_reg + 16'h0001);
	assign gap_next = nv_save ? 0 : gap_reg + 1;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= 0;
			hi_reg <= 16'h0000;
		end else begin
			gap_reg <= gap_next;
			hi_reg <= hi_next;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_save_once;
		nv_save ##1 !nv_save;
	endsequence
	a_save_pulse: assert property (nv_save |-> s_save_once)
		else $error("save strobe too long");
	a_mains_save: assert property ($rose(mains_lost) |-> ##1 s_save_once)
		else $error("no save on mains loss");
	a_save_period: assert property (gap_reg < SAVE_CYC + 2)
		else $error("periodic save missing");
	a_load_step: assert property ($changed(nv_rd_idx) |->
		nv_rd_idx == $past(nv_rd_idx) + 2'h1)
		else $error("load index out of order");
	a_ready_holds: assert property (ready |=> ready)
		else $error("ready dropped");
	a_unready_quiet: assert property (!ready |-> !tx_oe)
		else $error("transmit before ready");
	a_write_pulse: assert property (app_wr |=> !app_wr)
		else $error("write strobe too long");
	a_write_ready: assert property (app_wr |-> ready)
		else $error("write before ready");
	a_stop_length: assert property ($fell(txd) |-> hi_reg >= BIT_DIV)
		else $error("stop period too short");
	a_line_idle: assert property (!tx_oe |-> txd)
		else $error("line not idle high");
endmodule
bind mbs_slave mbs_slave_checker #(
	.MS_DIV(MS_DIV),
	.SAVE_MS(SAVE_MS),
	.BIT_DIV(BIT_DIV_HI)
) mbs_slave_checker_inst (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.txd(txd),
	.tx_oe(tx_oe),
	.nv_rd_idx(nv_rd_idx),
	.nv_save(nv_save),
	.mains_lost(mains_lost),
	.app_wr(app_wr),
	.ready(ready)
);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
	check_count++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("unexpected t=%0t got %h want %h", $time, a, b); \
	end \
end
module tb_top;
	import mbs_pkg::*;
	typedef struct packed {
		logic [47:0] req;
		logic [47:0] rsp;
		logic [3:0] n;
	} mbs_row_s;
	// ****
	// Request and expected reply, CRC excluded
	// ****
	localparam mbs_row_s ROWS[12] = '{
		{48'h010600001234, 48'h010600001234, 4'h6},
		{48'h010300000001, 48'h010302c61b00, 4'h5},
		{48'h010400000001, 48'h018401000000, 4'h3},
		{48'h010600fb000a, 48'h010600fb000a, 4'h6},
		{48'h010600fa0005, 48'h010600fa0005, 4'h6},
		{48'h050300fa0001, 48'h050302000500, 4'h5},
		{48'h010300fa0001, 48'h000000000000, 4'h0},
		{48'h050600260001, 48'h058602000000, 4'h3},
		{48'h050600fa0041, 48'h058603000000, 4'h3},
		{48'h050608979c67, 48'h050608979c67, 4'h6},
		{48'h050308330001, 48'h050302012300, 4'h5},
		{48'h050308340001, 48'h050302000000, 4'h5}
	};
	logic sys_clk, rst_n, rxd, txd, tx_oe, nv_save, mains_lost, app_wr, ready;
	logic wr_permit;
	logic [1:0] nv_rd_idx;
	logic [15:0] nv_rd_data, app_addr, app_rdata, app_wdata, wr_addr, wr_data;
	logic [15:0] temp_raw;
	int n_fail = 0;
	int check_count = 0;
	// Stored words: address 1, baud code 9, no parity, one stop bit
	assign nv_rd_data = (nv_rd_idx == 2'h1) ? 16'h0009 :
		{15'h0000, nv_rd_idx == 2'h0};
	assign app_rdata = app_addr ^ 16'h5a5a;
	mbs_slave #(.MS_DIV(10), .READY_MS(2), .SAVE_MS(5), .BIT_DIV_HI(8),
		.BIT_DIV_LO(16)) mbs_slave_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .rxd(rxd), .txd(txd),
		.tx_oe(tx_oe), .nv_rd_idx(nv_rd_idx), .nv_rd_data(nv_rd_data),
		.nv_save(nv_save), .mains_lost(mains_lost), .app_addr(app_addr),
		.app_rdata(app_rdata), .app_wr(app_wr), .app_wdata(app_wdata),
		.wr_permit(wr_permit), .temp_raw(temp_raw), .ready(ready));
	mbs_master_model #(.BIT_DIV(8)) mbs_master_model_inst (
		.sys_clk(sys_clk), .rxd(rxd), .txd(txd));
	always @(posedge sys_clk) begin
		if (app_wr === 1'b1) begin
			wr_addr <= app_addr;
			wr_data <= app_wdata;
		end
	end
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic run_row(input mbs_row_s r);
		logic [15:0] c;
		logic [7:0] q[$];
		mbs_master_model_inst.send(r.req);
		mbs_master_model_inst.recv();
		q = mbs_master_model_inst.rsp_q;
		`CHK(q.size(), r.n ? r.n + 2 : 0)
		for (int k = 0; k < r.n; k++)
			`CHK(q[k], r.rsp[47 - 8 * k -: 8])
		c = CRC_INIT;
		foreach (q[k])
			c = mbs_master_model_inst.crc_upd(c, q[k]);
		if (r.n != 4'h0)
			`CHK(c, 16'h0000)
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#500_000;
		n_fail++;
		end_of_test();
	end
	initial begin
		rst_n = 1'b0;
		mains_lost = 1'b0;
		wr_permit = 1'b1;
		temp_raw = 16'h0123;
		repeat (20) @(posedge sys_clk);
		`CHK({txd, tx_oe, ready, app_wr, nv_save}, 5'b10000)
		rst_n <= 1'b1;
		repeat (15) @(negedge sys_clk);
		`CHK(ready, 1'b0)
		for (int k = 0; k < 20 && ready !== 1'b1; k++)
			@(negedge sys_clk);
		`CHK(ready, 1'b1)
		for (int k = 0; k < 60 && nv_save !== 1'b1; k++)
			@(negedge sys_clk);
		`CHK(nv_save, 1'b1)
		@(posedge sys_clk);
		mains_lost <= 1'b1;
		// Line stays silent 40 more bit times, one past the 39-bit frame gap, before traffic
		mbs_master_model_inst.bits(40);
		for (int i = 0; i < 12; i++) begin
			run_row(ROWS[i]);
			if (i == 0)
				`CHK({wr_addr, wr_data}, 32'h9c411234)
		end
		wr_permit <= 1'b0;
		run_row('{48'h050600000077, 48'h058604000000, 4'h3});
		wr_permit <= 1'b1;
		`CHK({wr_addr, wr_data}, 32'h9c411234)
		// Power cycle: address reloads, pointer table empties
		rst_n <= 1'b0;
		mains_lost <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge sys_clk);
		`CHK({ready, nv_rd_idx}, 3'b001)
		repeat (40) @(posedge sys_clk);
		mbs_master_model_inst.bits(40);
		run_row('{48'h010600fa0001, 48'h010600fa0001, 4'h6});
		run_row('{48'h010308330001, 48'h010302000000, 4'h5});
		end_of_test();
	end
endmodule
